// File: src/brs_bridge_reset_sequencer.sv
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Level 0 clears all registers, sticky included
// - Release bus reset 1 ms after fundamental release
// - Reset message or link down gives hot reset
// - Hot reset: release bus 1 ms after internal
// - Load EEPROM after level 0/1, never level 2
// - Retry config requests while EEPROM loads
// - Software bus reset bit starts level 2
// - Level 2 holds longer of 1 ms, bit
// - Level 2 leaves configuration registers unchanged
// - Level 2 redetermines bus mode, and clock only as clock master
// - Drop PCI-side upstream requests, keep PCIe-side
// - Drop downstream requests, credits, UR non-posted

module brs_bridge_reset_sequencer #(
    // Release delay in cycles; a bench may shorten it, hardware keeps the default
    parameter int unsigned RELEASE_CYCLES = brs_pkg::RELEASE_CYCLES
) (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic upstream_fundamental_reset_n,
    input wire logic hotResetMessage,
    input wire logic linkDown,
    input wire logic busResetBit,
    input wire logic clockMaster,
    input wire logic eepromLoadDone,
    input wire logic busTrafficPending,
    input wire logic configRequest,
    output logic secondary_bus_reset_n,
    output logic eepromLoadStart,
    output logic configRetry,
    output brs_pkg::brs_reg_ctl_type regCtl,
    output brs_pkg::brs_drain_type drain,
    output logic [1:0] resetLevel
);

    ////////////////////////////////////////////////////////////////
    // Reset synchroniser: async assert, release after two edges
    logic rstMeta;
    logic rstN;
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rstMeta <= 1'b0;
            rstN <= 1'b0;
        end else begin
            rstMeta <= 1'b1;
            rstN <= rstMeta;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Fundamental reset: asserting clears at once, release is synchronised
    logic perstMeta;
    logic perstN;
    wire logic coldN = rstN && upstream_fundamental_reset_n;
    always_ff @(posedge mclk or negedge coldN) begin
        if (!coldN) begin
            perstMeta <= 1'b0;
            perstN <= 1'b0;
        end else begin
            perstMeta <= 1'b1;
            perstN <= perstMeta;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Link event and strap synchronisers; none of them share this clock
    logic [3:0] evMeta;
    logic [3:0] evSync;
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            evMeta <= 4'h0;
            evSync <= 4'h0;
        end else begin
            evMeta <= {clockMaster, busResetBit, linkDown, hotResetMessage};
            evSync <= evMeta;
        end
    end
    // Hot reset request, level sensitive so a held link-down stays in reset
    wire logic hotReq = evSync[0] || evSync[1];
    wire logic busReq = evSync[2];
    // Clock strap, synchronised like the events
    wire logic masterSync = evSync[3];

    ////////////////////////////////////////////////////////////////
    // State and timer
    brs_pkg::brs_state_type state;
    brs_pkg::brs_state_type next_state;
    logic timerStart;
    logic timerDone;
    logic [1:0] level;
    logic [1:0] next_level;

    brs_delay_timer #(
        .CYCLES(RELEASE_CYCLES)
    ) u_timer (
        .mclk(mclk),
        .rstN(perstN),
        .start(timerStart),
        .done(timerDone)
    );

    ////////////////////////////////////////////////////////////////
    // Decodes
    wire logic inCold = (state == brs_pkg::ST_COLD);
    wire logic inHold = (state == brs_pkg::ST_HOLD);
    wire logic inLoad = (state == brs_pkg::ST_LOAD);
    wire logic inRun = (state == brs_pkg::ST_RUN);
    wire logic inBus = (state == brs_pkg::ST_BUS);
    // Hot reset is honoured from any non-cold state
    wire logic hotNow = hotReq && !inCold;
    // Bus reset only from normal running
    wire logic busNow = busReq && inRun && !hotReq;
    // Timer restarts on leaving cold, in every cycle of a hot request, on bus entry
    assign timerStart = inCold || hotNow || busNow;

    ////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        next_state = state;
        next_level = level;
        unique case (state)
            brs_pkg::ST_COLD: begin
                // First synchronised edge after release
                next_state = brs_pkg::ST_HOLD;
                next_level = brs_pkg::LEVEL_COLD;
            end
            brs_pkg::ST_HOLD: begin
                // Internal reset done; wait the full release delay
                if (hotNow) begin
                    next_level = brs_pkg::LEVEL_HOT;
                end else if (timerDone) begin
                    next_state = brs_pkg::ST_LOAD;
                end
            end
            brs_pkg::ST_LOAD: begin
                if (hotNow) begin
                    next_state = brs_pkg::ST_HOLD;
                    next_level = brs_pkg::LEVEL_HOT;
                end else if (eepromLoadDone) begin
                    next_state = brs_pkg::ST_RUN;
                    next_level = brs_pkg::LEVEL_NONE;
                end
            end
            brs_pkg::ST_RUN: begin
                if (hotNow) begin
                    next_state = brs_pkg::ST_HOLD;
                    next_level = brs_pkg::LEVEL_HOT;
                end else if (busNow) begin
                    next_state = brs_pkg::ST_BUS;
                    next_level = brs_pkg::LEVEL_BUS;
                end
            end
            brs_pkg::ST_BUS: begin
                // Longer of delay and software clear; no EEPROM load after
                if (hotNow) begin
                    next_state = brs_pkg::ST_HOLD;
                    next_level = brs_pkg::LEVEL_HOT;
                end else if (timerDone && !busReq) begin
                    next_state = brs_pkg::ST_RUN;
                    next_level = brs_pkg::LEVEL_NONE;
                end
            end
            default: begin
                // Illegal code: fall back to a full cold sequence
                next_state = brs_pkg::ST_COLD;
                next_level = brs_pkg::LEVEL_COLD;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////
    // State register, cleared by fundamental reset
    always_ff @(posedge mclk or negedge perstN) begin
        if (!perstN) begin
            state <= brs_pkg::ST_COLD;
            level <= brs_pkg::LEVEL_COLD;
        end else begin
            state <= next_state;
            level <= next_level;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Output decodes
    wire logic busActive = inCold || inHold || inBus || hotNow || busNow;
    wire logic loadEnter = inHold && timerDone && !hotNow;
    // Drain only when traffic is left; software should have emptied it
    wire logic drainNow = (busNow || hotNow) && busTrafficPending;
    brs_pkg::brs_reg_ctl_type next_regCtl;
    brs_pkg::brs_drain_type next_drain;
    assign next_regCtl.clearAll = inCold;
    assign next_regCtl.clearNonSticky = hotNow;
    assign next_regCtl.redetermineMode = busNow;
    assign next_regCtl.redetermineClock = busNow && masterSync;
    assign next_drain.dropPciUpstream = drainNow;
    assign next_drain.dropDownstream = drainNow;
    assign next_drain.returnCredits = drainNow;
    assign next_drain.urForNonPosted = drainNow;

    ////////////////////////////////////////////////////////////////
    // Registered outputs; cold reset holds bus reset and retry
    always_ff @(posedge mclk or negedge perstN) begin
        if (!perstN) begin
            secondary_bus_reset_n <= brs_pkg::BUS_RESET_N_INIT;
            eepromLoadStart <= brs_pkg::LOAD_REQ_INIT;
            configRetry <= 1'b1;
            regCtl <= '{clearAll: 1'b1, default: 1'b0};
            drain <= '0;
            resetLevel <= brs_pkg::LEVEL_COLD;
        end else begin
            secondary_bus_reset_n <= !busActive;
            eepromLoadStart <= loadEnter;
            // Retry covers load and the hold before it
            configRetry <= (inHold || inLoad || inCold) && !(inLoad && eepromLoadDone);
            regCtl <= next_regCtl;
            drain <= next_drain;
            resetLevel <= next_level;
        end
    end

    // The config request itself is answered by the PCIe core using configRetry
    wire logic unusedReq = configRequest;

endmodule

`default_nettype wire

// File: src/brs_pkg.sv
package brs_pkg;

    // Clock rate in kHz (250 MHz)
    localparam int unsigned CLK_KHZ = 250000;
    // Release delay after each reset, in ms
    localparam int unsigned RELEASE_MS = 1;
    // Cycles for the release delay, exact product of ms and kHz
    localparam int unsigned RELEASE_CYCLES = RELEASE_MS * CLK_KHZ;
    // Counter width for the release delay
    localparam int unsigned CNT_W = 20;

    // Reset level codes
    localparam logic [1:0] LEVEL_NONE = 2'h0;
    localparam logic [1:0] LEVEL_COLD = 2'h1;
    localparam logic [1:0] LEVEL_HOT = 2'h2;
    localparam logic [1:0] LEVEL_BUS = 2'h3;

    // Reset values of outputs
    localparam logic BUS_RESET_N_INIT = 1'b0;
    localparam logic LOAD_REQ_INIT = 1'b0;

    // Sequencer states, Gray along the usual path
    typedef enum logic [2:0] {
        ST_COLD = 3'h0,
        ST_HOLD = 3'h1,
        ST_LOAD = 3'h3,
        ST_RUN = 3'h2,
        ST_BUS = 3'h6
    } brs_state_type;

    // Control strobes to the register core
    typedef struct packed {
        logic clearAll;
        logic clearNonSticky;
        logic redetermineMode;
        logic redetermineClock;
    } brs_reg_ctl_type;

    // Buffer drain commands
    typedef struct packed {
        logic dropPciUpstream;
        logic dropDownstream;
        logic returnCredits;
        logic urForNonPosted;
    } brs_drain_type;

endpackage

// File: src/brs_delay_timer.sv
`timescale 1ns/1ps
`default_nettype none

// Counts a fixed delay once started; restart reloads it
module brs_delay_timer #(
    parameter int unsigned CYCLES = brs_pkg::RELEASE_CYCLES
) (
    input wire logic mclk,
    input wire logic rstN,
    input wire logic start,
    output logic done
);

    // Remaining cycles; zero means idle or expired
    logic [brs_pkg::CNT_W-1:0] count;
    // Armed after a start until expiry
    logic running;
    wire logic lastTick = running && (count == brs_pkg::CNT_W'(1));

    ////////////////////////////////////////////////////////////////
    // Countdown; start wins over expiry so a restart is never lost
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            count <= '0;
            running <= 1'b0;
            done <= 1'b0;
        end else if (start) begin
            count <= brs_pkg::CNT_W'(CYCLES);
            running <= 1'b1;
            done <= 1'b0;
        end else if (lastTick) begin
            count <= '0;
            running <= 1'b0;
            done <= 1'b1;
        end else if (running) begin
            count <= count - brs_pkg::CNT_W'(1);
        end
    end

endmodule

`default_nettype wire

// File: testbench/brs_eeprom_model.sv
`timescale 1ns/1ps
`default_nettype none

// Serial configuration loader stand-in
module brs_eeprom_model #(
    parameter int unsigned LOAD_CYCLES = 8
) (
    input wire logic mclk,
    input wire logic rstN,
    input wire logic loadStart,
    output logic loadDone
);
    int unsigned left; // Cycles still to load
    // Fixed short load; a real part takes far longer, which only stretches the retry window
    always @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            left <= 0;
            loadDone <= 1'b0;
        end else begin
            loadDone <= (left == 1);
            left <= loadStart ? LOAD_CYCLES : (left != 0 ? left - 1 : 0);
        end
    end
endmodule

`default_nettype wire

// File: testbench/brs_bridge_reset_sequencer_chk.sv
`timescale 1ns/1ps
`default_nettype none

module brs_bridge_reset_sequencer_chk #(
    parameter int unsigned RELEASE_CYCLES = brs_pkg::RELEASE_CYCLES
) (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic upstream_fundamental_reset_n,
    input wire logic hotResetMessage,
    input wire logic linkDown,
    input wire logic busResetBit,
    input wire logic clockMaster,
    input wire logic eepromLoadDone,
    input wire logic secondary_bus_reset_n,
    input wire logic eepromLoadStart,
    input wire logic configRetry,
    input wire brs_pkg::brs_reg_ctl_type regCtl,
    input wire logic [1:0] resetLevel
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);
    int unsigned since; // Cycles since the last reset cause
    ////////////////////////////////////////////////////////////
    // Restart on any cause; bit counts from its set edge only
    always_ff @(posedge mclk) begin
        since <= (!upstream_fundamental_reset_n || hotResetMessage || linkDown || $rose(busResetBit)) ? 0 : since + 1;
    end
    property p_cold;
        !upstream_fundamental_reset_n |-> regCtl.clearAll && resetLevel == brs_pkg::LEVEL_COLD;
    endproperty
    a_cold: assert property (p_cold) else $error("cold reset not applied");
    property p_cold_bus;
        !upstream_fundamental_reset_n |-> !secondary_bus_reset_n;
    endproperty
    a_cold_bus: assert property (p_cold_bus) else $error("bus reset not driven");
    property p_release;
        $rose(secondary_bus_reset_n) |-> since >= RELEASE_CYCLES;
    endproperty
    a_release: assert property (p_release) else $error("bus reset released early");
    property p_hot;
        (hotResetMessage || linkDown) && upstream_fundamental_reset_n
            |-> ##[1:5] (!secondary_bus_reset_n && resetLevel == brs_pkg::LEVEL_HOT);
    endproperty
    a_hot: assert property (p_hot) else $error("hot reset missed");
    property p_bus;
        $rose(busResetBit) && secondary_bus_reset_n && !configRetry
            |-> ##[1:5] (!secondary_bus_reset_n && resetLevel == brs_pkg::LEVEL_BUS);
    endproperty
    a_bus: assert property (p_bus) else $error("bus reset missed");
    property p_bus_keep;
        resetLevel == brs_pkg::LEVEL_BUS |-> !regCtl.clearAll && !regCtl.clearNonSticky;
    endproperty
    a_bus_keep: assert property (p_bus_keep) else $error("bus reset cleared registers");
    property p_bus_noload;
        resetLevel == brs_pkg::LEVEL_BUS |-> !eepromLoadStart;
    endproperty
    a_bus_noload: assert property (p_bus_noload) else $error("bus reset started load");
    property p_retry;
        $fell(configRetry) |-> $past(eepromLoadDone);
    endproperty
    a_retry: assert property (p_retry) else $error("retry ended before load");
    property p_clock;
        regCtl.redetermineMode |-> regCtl.redetermineClock == clockMaster;
    endproperty
    a_clock: assert property (p_clock) else $error("clock redone as slave");
endmodule

bind brs_bridge_reset_sequencer brs_bridge_reset_sequencer_chk #(.RELEASE_CYCLES(RELEASE_CYCLES)) chk_u (.*);

`default_nettype wire

// File: testbench/test_bridge_reset_sequencer.sv
`timescale 1ns/1ps
`default_nettype none

module test_bridge_reset_sequencer;
    localparam int REL = 1000; // Shortened release delay; full length would take far too long
    localparam int LIMIT = 30000; // About eighteen release delays and margin
    typedef struct packed {
        logic [4:0] stim; // Hot, link, bit, master, traffic
        logic [1:0] level;
        logic [7:0] seen; // Load, clock, mode, nonsticky, drain
        logic [7:0] mask; // Hot cases leave clock/mode open
    } brs_row_type;
    brs_row_type rows [4];
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic fundN = 1'b0;
    logic hotMsg = 1'b0;
    logic linkDown = 1'b0;
    logic busBit = 1'b0;
    logic master = 1'b0;
    logic traffic = 1'b0;
    logic loadDone, busN, loadStart, retry;
    logic [1:0] level;
    logic [7:0] seen = 8'h00; // Sticky record of pulses
    logic seenClr = 1'b1; // Holds the record empty; also hides unknowns before reset
    brs_pkg::brs_reg_ctl_type regCtl;
    brs_pkg::brs_drain_type drain;
    int mismatches = 0;
    int checks_done = 0;
    int cyc = 0;

    always #2 mclk = ~mclk;
    brs_bridge_reset_sequencer #(.RELEASE_CYCLES(REL)) dut_u (.mclk(mclk), .arst_n(arst_n),
        .upstream_fundamental_reset_n(fundN),
        .hotResetMessage(hotMsg), .linkDown(linkDown), .busResetBit(busBit), .clockMaster(master),
        .eepromLoadDone(loadDone), .busTrafficPending(traffic), .configRequest(1'b1),
        .secondary_bus_reset_n(busN), .eepromLoadStart(loadStart), .configRetry(retry),
        .regCtl(regCtl), .drain(drain), .resetLevel(level));
    brs_eeprom_model eep_u (.mclk(mclk), .rstN(arst_n), .loadStart(loadStart), .loadDone(loadDone));
    ////////////////////////////////////////////////////////////
    // Cycle count, pulse record, hang guard
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        seen <= seenClr ? 8'h00
            : (seen | {loadStart, regCtl.redetermineClock, regCtl.redetermineMode, regCtl.clearNonSticky, drain});
        if (cyc == LIMIT) begin
            mismatches++;
            test_done();
        end
    end
    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Bounded wait for bus release, then its delay is judged
    task automatic waitBus(input int lo, input int hi);
        int n;
        n = 0;
        while (busN !== 1'b1 && n <= hi) begin
            step(1);
            n++;
        end
        check({15'h0000, n >= lo && n <= hi}, 16'h0001);
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        rows = '{'{5'h11, brs_pkg::LEVEL_HOT, 8'h9f, 8'h9f}, '{5'h08, brs_pkg::LEVEL_HOT, 8'h90, 8'h9f},
            '{5'h07, brs_pkg::LEVEL_BUS, 8'h6f, 8'hff}, '{5'h04, brs_pkg::LEVEL_BUS, 8'h20, 8'hff}};
        step(4);
        check({regCtl.clearAll, busN, level}, {2'h2, brs_pkg::LEVEL_COLD});
        arst_n = 1'b1;
        seenClr = 1'b0;
        // Fundamental stays low well past clock start
        step(10 * REL);
        check({regCtl.clearAll, busN, level}, {2'h2, brs_pkg::LEVEL_COLD});
        fundN = 1'b1;
        waitBus(REL, REL + 20);
        check(retry, 1'b1);
        step(20);
        check({seen[7], retry}, 2'h2);
        // Hot triggers hold the level; the bus bit outlasts the delay
        foreach (rows[i]) begin
            {hotMsg, linkDown, busBit, master, traffic} = rows[i].stim;
            seenClr = 1'b1;
            step(1);
            seenClr = 1'b0;
            step(9);
            check({busN, level}, {1'b0, rows[i].level});
            hotMsg = 1'b0;
            linkDown = 1'b0;
            if (busBit) begin
                step(REL + 50);
                check(busN, 1'b0);
                busBit = 1'b0;
                waitBus(0, 10);
            end else begin
                waitBus(REL, REL + 20);
            end
            step(20);
            check(seen & rows[i].mask, rows[i].seen);
        end
        // Bit cleared early: the delay alone sets the release
        busBit = 1'b1;
        step(10);
        check({busN, level}, {1'b0, brs_pkg::LEVEL_BUS});
        busBit = 1'b0;
        waitBus(REL - 10, REL + 10);
        // Fundamental drop in mid-run, held a full warm pulse, then released
        fundN = 1'b0;
        step(2);
        check({regCtl.clearAll, busN, level}, {2'h2, brs_pkg::LEVEL_COLD});
        step(REL);
        fundN = 1'b1;
        waitBus(REL, REL + 20);
        test_done();
    end
endmodule

`default_nettype wire
